// [design/uwake_baud_gen.sv]
/*
 * baud tick divider: one enable pulse every (divisor+1) clocks, which is a quarter
 * of a bit time, so bit rate = fclk / (4 * (divisor+1)).
 * assumes: single clock, synchronous active-high reset, run gated by the caller.
 */
`timescale 1ns/1ps

module uwake_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    output      logic             tick
);
    logic [DIV_W-1:0] cnt_ff;

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            cnt_ff <= '0;
            tick   <= 1'b0;
        end else if (cnt_ff >= divisor) begin
            cnt_ff <= '0;
            tick   <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick   <= 1'b0;
        end
    end

    // with divisor 3 held, ticks come exactly divisor+1 = 4 clocks apart
    chk_tick_period: assert property (@(posedge clk) disable iff (sys_rst || !run) // [R13]
        $rose(tick) && divisor == DIV_W'(3) && $stable(divisor) |-> ##1 !tick [*3] ##1 tick)
        else $error("baud tick period wrong");
endmodule

// [design/uwake_defines.svh]
/*
 * constants for the serial wake-up detector: register offsets, field positions,
 * reset values and timing figures.
 * assumes: included by bare name from the package, uwake_top and the bench.
 */
`ifndef UWAKE_DEFINES_SVH
`define UWAKE_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define UWAKE_OFF_BAUD_CTRL   12'h000
`define UWAKE_OFF_DIVISOR     12'h004
`define UWAKE_OFF_BUFFER      12'h008
`define UWAKE_OFF_STATUS      12'h00c
`define UWAKE_OFF_INT_STAT    12'h010
`define UWAKE_OFF_INT_MASK    12'h014

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UWAKE_BIT_WIDE_DIV    0
`define UWAKE_BIT_WAKE_EN     1
`define UWAKE_BIT_HIGH_SPEED  2
`define UWAKE_BIT_SYNC_MODE   3
`define UWAKE_BIT_SLEEP       4
`define UWAKE_BIT_RX_FLAG     0
`define UWAKE_BIT_RX_IDLE     1
`define UWAKE_BIT_FRAME_ERR   2
`define UWAKE_IRQ_RX          0
`define UWAKE_IRQ_WAKE        1
`define UWAKE_IRQ_WAKE_DONE   2

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define UWAKE_RST_CTRL        8'h00
`define UWAKE_RST_DIVISOR     16'h0410
`define UWAKE_DIVISOR_W       16
`define UWAKE_OVERSAMPLE      4
`define UWAKE_MID_SAMPLE      2
`define UWAKE_DATA_BITS       8

`endif

// [design/uwake_pkg.sv]
/*
 * types shared by the serial wake-up detector.
 * assumes: uwake_defines.svh is on the include path.
 */
`include "uwake_defines.svh"

package uwake_pkg;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } uwake_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } uwake_apb_rsp_type;

    typedef enum logic [1:0] {
        UWAKE_RX_IDLE  = 2'b00,
        UWAKE_RX_START = 2'b01,
        UWAKE_RX_DATA  = 2'b10,
        UWAKE_RX_STOP  = 2'b11
    } uwake_rx_state_type;

endpackage

// [design/uwake_top.sv]
/*
 * serial receiver with auto-wake-up on a break: APB registers, receive path,
 * falling-edge wake detection and interrupt logic.
 * assumes: APB master on clk; receive_line synchronous-domain input via synchroniser;
 * the sleep bit of baud_control_reg stops the baud generator while set.
 */
// How it works
// [R1] While asleep the baud generator gets no ticks, so no byte can complete.
// [R2] Setting wake_on_edge_enable, bit 1 of baud_control_reg, arms wake-up, only in async mode.
// [R3] While armed the receiver stays idle and only watches the line.
// [R4] A high-to-low change on receive_line is the wake event.
// [R5] The wake event sets receive_flag at once, awake or asleep.
// [R6] Reading receive_buffer clears receive_flag; the int_stat_ff receive bit stays set until the interrupt status register is read.
// [R7] The next rising edge after the wake event clears wake_on_edge_enable and normal reception resumes.
// [R8] The sender must make the first character all zeros.
// [R9] The sender must hold the break and idle long enough for start-up.
// [R10] Software discards the buffer byte read after a wake.
// [R11] Software does not treat the flags as proof of data integrity.
// [R12] Software checks receiver_idle_flag before arming and sleeping.
// [R13] The bit rate is fclk over four times divisor plus one in wide high-speed mode.
// [R14] receive_line passes a two-stage synchroniser before edge detection.
`timescale 1ns/1ps
`include "uwake_defines.svh"

module uwake_top (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire uwake_pkg::uwake_apb_req_type apb_req,
    output      uwake_pkg::uwake_apb_rsp_type apb_rsp,
    input  wire logic                         receive_line,
    output      logic                         irq
);
    import uwake_pkg::*;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]                   ctrl_ff;
    logic [`UWAKE_DIVISOR_W-1:0]  divisor_ff;
    logic [7:0]                   receive_buffer_ff;
    logic                         receive_flag_ff;
    logic                         frame_err_ff;
    logic [2:0]                   int_stat_ff;
    logic [2:0]                   int_mask_ff;
    logic                         wake_seen_ff;
    logic                         sync1_ff;
    logic                         sync2_ff;
    logic                         line_prev_ff;
    uwake_rx_state_type           rx_state_ff;
    logic [1:0]                   phase_ff;
    logic [2:0]                   bit_idx_ff;
    logic [7:0]                   shift_ff;

    logic wr_en;
    logic rd_en;
    logic fall_edge;
    logic rise_edge;
    logic tick;
    logic byte_done;
    logic wake_event;
    logic wake_clear;
    logic buf_read;
    logic stat_read;
    logic wake_en;
    logic async_mode;
    logic asleep;
    logic [31:0] nxt_rdata;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        return addr[11:2] == off[11:2];
    endfunction

    assign wr_en      = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en      = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign wake_en    = ctrl_ff[`UWAKE_BIT_WAKE_EN];
    assign async_mode = !ctrl_ff[`UWAKE_BIT_SYNC_MODE];
    assign asleep     = ctrl_ff[`UWAKE_BIT_SLEEP];
    assign buf_read   = rd_en && hit(apb_req.paddr, `UWAKE_OFF_BUFFER);
    assign stat_read  = rd_en && hit(apb_req.paddr, `UWAKE_OFF_INT_STAT);

    // ------------------------------------------------------------------------
    // receive line synchroniser and edges
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff     <= 1'b1;
            sync2_ff     <= 1'b1;
            line_prev_ff <= 1'b1;
        end else begin
            sync1_ff     <= receive_line;   // [R14]
            sync2_ff     <= sync1_ff;       // [R14]
            line_prev_ff <= sync2_ff;
        end
    end

    assign fall_edge  = line_prev_ff && !sync2_ff;
    assign rise_edge  = !line_prev_ff && sync2_ff;
    // armed in async mode only; edge recognised even while asleep
    assign wake_event = wake_en && async_mode && !wake_seen_ff && fall_edge;   // [R2] [R4]
    assign wake_clear = wake_en && wake_seen_ff && rise_edge;                  // [R7]

    // ------------------------------------------------------------------------
    // control, divisor and wake tracking
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= `UWAKE_RST_CTRL;
        end else if (wake_clear) begin
            ctrl_ff[`UWAKE_BIT_WAKE_EN] <= 1'b0;   // [R7]
        end else if (wr_en && hit(apb_req.paddr, `UWAKE_OFF_BAUD_CTRL)) begin
            ctrl_ff <= apb_req.pwdata[7:0];        // [R2]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divisor_ff <= `UWAKE_RST_DIVISOR;
        end else if (wr_en && hit(apb_req.paddr, `UWAKE_OFF_DIVISOR)) begin
            divisor_ff <= apb_req.pwdata[`UWAKE_DIVISOR_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !wake_en) begin
            wake_seen_ff <= 1'b0;
        end else if (wake_event) begin
            wake_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // baud generator and receiver
    // ------------------------------------------------------------------------
    uwake_baud_gen #(
        .DIV_W   (`UWAKE_DIVISOR_W)
    ) u_baud (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (!asleep && !wake_en),   // [R1] [R3]
        .divisor (divisor_ff),            // [R13]
        .tick    (tick)
    );

    always_ff @(posedge clk) begin
        if (sys_rst || wake_en) begin
            rx_state_ff <= UWAKE_RX_IDLE;   // [R3]
            phase_ff    <= '0;
            bit_idx_ff  <= '0;
            shift_ff    <= '0;
        end else begin
            unique case (rx_state_ff)
                UWAKE_RX_IDLE: begin
                    phase_ff   <= '0;
                    bit_idx_ff <= '0;
                    if (fall_edge) begin
                        rx_state_ff <= UWAKE_RX_START;
                    end
                end
                UWAKE_RX_START: begin
                    if (tick) begin
                        phase_ff <= phase_ff + 2'd1;
                        if (phase_ff == 2'(`UWAKE_MID_SAMPLE - 1)) begin
                            if (sync2_ff) begin
                                rx_state_ff <= UWAKE_RX_IDLE;
                            end else begin
                                rx_state_ff <= UWAKE_RX_DATA;
                                phase_ff    <= '0;
                            end
                        end
                    end
                end
                UWAKE_RX_DATA: begin
                    if (tick) begin
                        phase_ff <= phase_ff + 2'd1;
                        if (phase_ff == 2'(`UWAKE_OVERSAMPLE - 1)) begin
                            shift_ff   <= {sync2_ff, shift_ff[7:1]};
                            bit_idx_ff <= bit_idx_ff + 3'd1;
                            if (bit_idx_ff == 3'(`UWAKE_DATA_BITS - 1)) begin
                                rx_state_ff <= UWAKE_RX_STOP;
                            end
                        end
                    end
                end
                UWAKE_RX_STOP: begin
                    if (tick) begin
                        phase_ff <= phase_ff + 2'd1;
                        if (phase_ff == 2'(`UWAKE_OVERSAMPLE - 1)) begin
                            rx_state_ff <= UWAKE_RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign byte_done = (rx_state_ff == UWAKE_RX_STOP) && tick && !wake_en
                       && (phase_ff == 2'(`UWAKE_OVERSAMPLE - 1));

    // ------------------------------------------------------------------------
    // receive buffer and flags
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            receive_buffer_ff <= '0;
            frame_err_ff      <= 1'b0;
        end else if (byte_done) begin
            receive_buffer_ff <= shift_ff;
            frame_err_ff      <= !sync2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            receive_flag_ff <= 1'b0;
        end else if (wake_event || byte_done) begin
            receive_flag_ff <= 1'b1;   // [R5]
        end else if (buf_read) begin
            receive_flag_ff <= 1'b0;   // [R6]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_stat_ff <= '0;
        end else begin
            int_stat_ff <= (stat_read ? 3'b000 : int_stat_ff)
                           | {wake_clear, wake_event, wake_event || byte_done};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_mask_ff <= '0;
        end else if (wr_en && hit(apb_req.paddr, `UWAKE_OFF_INT_MASK)) begin
            int_mask_ff <= apb_req.pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_ff & int_mask_ff) || (receive_flag_ff && int_mask_ff[`UWAKE_IRQ_RX]);
        end
    end

    // ------------------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_rdata = '0;
        if (hit(apb_req.paddr, `UWAKE_OFF_BAUD_CTRL)) begin
            nxt_rdata[7:0] = ctrl_ff;
        end else if (hit(apb_req.paddr, `UWAKE_OFF_DIVISOR)) begin
            nxt_rdata[`UWAKE_DIVISOR_W-1:0] = divisor_ff;
        end else if (hit(apb_req.paddr, `UWAKE_OFF_BUFFER)) begin
            nxt_rdata[7:0] = receive_buffer_ff;
        end else if (hit(apb_req.paddr, `UWAKE_OFF_STATUS)) begin
            nxt_rdata[`UWAKE_BIT_RX_FLAG]   = receive_flag_ff;
            nxt_rdata[`UWAKE_BIT_RX_IDLE]   = rx_state_ff == UWAKE_RX_IDLE;
            nxt_rdata[`UWAKE_BIT_FRAME_ERR] = frame_err_ff;
        end else if (hit(apb_req.paddr, `UWAKE_OFF_INT_STAT)) begin
            nxt_rdata[2:0] = int_stat_ff;
        end else if (hit(apb_req.paddr, `UWAKE_OFF_INT_MASK)) begin
            nxt_rdata[2:0] = int_mask_ff;
        end
    end

    // no wait state: pready rises in the first access cycle, data registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
            apb_rsp.prdata  <= nxt_rdata;
            apb_rsp.pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_wake_sets_flag: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        wake_event |=> receive_flag_ff)
        else $error("wake event did not set receive flag");
    chk_read_clears_flag: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        buf_read && !wake_event && !byte_done |=> !receive_flag_ff)
        else $error("buffer read did not clear flag");
    chk_rise_clears_en: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        wake_en && wake_seen_ff && rise_edge |=> !wake_en)
        else $error("rising edge did not clear wake enable");
    chk_armed_idle: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
        wake_en |=> !byte_done)
        else $error("byte completed while armed");
    chk_sleep_no_tick: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        asleep && $past(asleep) |-> !tick)
        else $error("baud tick while asleep");
    chk_fall_wakes: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        wake_en && async_mode && !wake_seen_ff && $fell(sync2_ff) |=> wake_seen_ff)
        else $error("falling edge missed");
    chk_sync_mode_blocks: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        !async_mode |-> !wake_event)
        else $error("wake in sync mode");
    chk_sync_chain: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
        ##2 1 |-> sync2_ff == $past(receive_line, 2))
        else $error("synchroniser depth wrong");
endmodule

// [verification/tb.sv]
/*
 * self-checking bench for the serial wake-up detector, apb register access.
 * assumes: uwake_pkg compiled first; uwake_defines.svh on the include path.
 */
`timescale 1ns/1ps
`include "uwake_defines.svh"

module tb;
    import uwake_pkg::*;

    localparam int DIV  = 3;
    localparam int BITC = 4 * (DIV + 1);

    logic              clk;
    logic              sys_rst;
    uwake_apb_req_type apb_req;
    uwake_apb_rsp_type apb_rsp;
    logic              receive_line;
    logic              irq;
    int                n_mismatch;
    int                checked;

    uwake_top dut (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
                   .receive_line(receive_line), .irq(irq));
    uwake_remote_tx tx (.clk(clk), .line(receive_line));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        apb_req.paddr   <= a;
        apb_req.pwrite  <= w;
        apb_req.pwdata  <= wd;
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        chk({31'h0, apb_rsp.pready}, 32'h1, "pready");
        chk({31'h0, apb_rsp.pslverr}, 32'h0, "pslverr");
        rd = apb_rsp.prdata;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(a, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        logic [31:0] x;
        apb(a, 1'b0, 32'h0, x);
        chk(x & m, e, what);
    endtask

    // reads until the masked value matches or the tries run out
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input int tries, input string what);
        logic [31:0] x;
        for (int i = 0; i < tries; i++) begin
            apb(a, 1'b0, 32'h0, x);
            if ((x & m) === e) break;
        end
        chk(x & m, e, what);
    endtask

    task automatic rx_byte(input logic [7:0] b);
        tx.send_byte(b, BITC);
        poll(`UWAKE_OFF_STATUS, 32'h1, 32'h1, 8, "byte flag");
        rd_chk(`UWAKE_OFF_BUFFER, 32'hff, {24'h0, b}, "byte data");
        rd_chk(`UWAKE_OFF_STATUS, 32'h5, 32'h0, "flag after read");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd_chk(`UWAKE_OFF_BAUD_CTRL, 32'hff, 32'h0, "ctrl reset");
        rd_chk(`UWAKE_OFF_DIVISOR, 32'hffffffff, 32'h410, "divisor reset");
        wr(12'h020, 32'hffffffff);
        rd_chk(12'h020, 32'hffffffff, 32'h0, "unmapped");
        wr(`UWAKE_OFF_DIVISOR, DIV);
        rd_chk(`UWAKE_OFF_DIVISOR, 32'hffffffff, DIV, "divisor");
        rx_byte(8'h3c);
    endtask

    task automatic t_wake();
        wr(`UWAKE_OFF_INT_MASK, 32'h2);
        rd_chk(`UWAKE_OFF_STATUS, 32'h2, 32'h2, "idle before arm");
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h2);
        rd_chk(`UWAKE_OFF_BAUD_CTRL, 32'h2, 32'h2, "armed");
        tx.break_start();
        poll(`UWAKE_OFF_STATUS, 32'h1, 32'h1, 3, "wake flag");
        chk({31'h0, irq}, 32'h1, "irq on wake");
        rd_chk(`UWAKE_OFF_INT_STAT, 32'h2, 32'h2, "wake cause");
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd_chk(`UWAKE_OFF_BUFFER, 32'hff, 32'h3c, "dummy read");
        rd_chk(`UWAKE_OFF_STATUS, 32'h1, 32'h0, "flag cleared");
        repeat (12 * BITC) @(posedge clk);
        rd_chk(`UWAKE_OFF_STATUS, 32'h1, 32'h0, "no byte while armed");
        rd_chk(`UWAKE_OFF_BAUD_CTRL, 32'h2, 32'h2, "armed while low");
        tx.break_end();
        poll(`UWAKE_OFF_BAUD_CTRL, 32'h2, 32'h0, 3, "enable cleared");
        rx_byte(8'ha5);
    endtask

    task automatic t_sleep();
        wr(`UWAKE_OFF_INT_MASK, 32'h0);
        wr(`UWAKE_OFF_INT_STAT, 32'h0);
        rd_chk(`UWAKE_OFF_INT_STAT, 32'h7, 32'h5, "drain causes");
        rd_chk(`UWAKE_OFF_INT_STAT, 32'h7, 32'h0, "causes cleared");
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h10);
        tx.send_byte(8'h5a, BITC);
        rd_chk(`UWAKE_OFF_STATUS, 32'h1, 32'h0, "no byte asleep");
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h12);
        tx.break_start();
        poll(`UWAKE_OFF_STATUS, 32'h1, 32'h1, 3, "wake asleep");
        chk({31'h0, irq}, 32'h0, "masked irq");
        rd_chk(`UWAKE_OFF_INT_STAT, 32'h2, 32'h2, "masked cause kept");
        rd_chk(`UWAKE_OFF_BUFFER, 32'hff, 32'ha5, "dummy read");
        repeat (12 * BITC) @(posedge clk);
        tx.break_end();
        poll(`UWAKE_OFF_BAUD_CTRL, 32'h2, 32'h0, 3, "enable cleared asleep");
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h0);
    endtask

    task automatic t_sync();
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h0a);
        tx.break_start();
        repeat (20) @(posedge clk);
        rd_chk(`UWAKE_OFF_STATUS, 32'h1, 32'h0, "no wake in sync");
        tx.break_end();
        wr(`UWAKE_OFF_BAUD_CTRL, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        sys_rst    = 1'b1;
        apb_req    = '0;
        n_mismatch = 0;
        checked    = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_wake();
        t_sleep();
        t_sync();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule

// [verification/uwake_remote_tx.sv]
/*
 * remote serial sender for the wake-up detector bench: framed bytes and breaks.
 * assumes: shares the bench clock; receive_line idles high between frames.
 */
`timescale 1ns/1ps

module uwake_remote_tx (
    input  wire logic clk,
    output      logic line
);
    // ------------------------------------------------------------------
    // idle level
    // ------------------------------------------------------------------
    initial begin
        line = 1'b1;
    end

    // ------------------------------------------------------------------
    // frames
    // ------------------------------------------------------------------
    // start bit, eight data bits lsb first, one stop bit, then idle time
    task automatic send_byte(input logic [7:0] b, input int bitc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            line <= fr[i];
            repeat (bitc - 1) @(posedge clk);
        end
        repeat (2 * bitc) @(posedge clk);
    endtask

    // break: line held low, an all-zero character for as long as the caller waits
    task automatic break_start();
        @(posedge clk);
        line <= 1'b0;
    endtask

    task automatic break_end();
        @(posedge clk);
        line <= 1'b1;
    endtask
endmodule
